/* File: src/rtsr_pkg.sv */
package rtsr_pkg;

    // Bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_TSC = 10'h2f0;
    localparam logic [9:0]  IDX_LVC = 10'h2f1;
    localparam logic [9:0]  IDX_PWC = 10'h2f2;
    localparam logic [9:0]  IDX_PWT = 10'h2f3;
    localparam logic [9:0]  IDX_PWH = 10'h2f4;
    localparam logic [9:0]  IDX_PWL = 10'h2f5;
    localparam logic [9:0]  IDX_RSV = 10'h2f6;
    localparam logic [9:0]  IDX_HTT = 10'h2f7;
    localparam logic [11:0] ADR_TSC = {IDX_TSC, 2'b00};
    localparam logic [11:0] ADR_LVC = {IDX_LVC, 2'b00};
    localparam logic [11:0] ADR_PWC = {IDX_PWC, 2'b00};
    localparam logic [11:0] ADR_PWT = {IDX_PWT, 2'b00};
    localparam logic [11:0] ADR_PWH = {IDX_PWH, 2'b00};
    localparam logic [11:0] ADR_PWL = {IDX_PWL, 2'b00};
    localparam logic [11:0] ADR_RSV = {IDX_RSV, 2'b00};
    localparam logic [11:0] ADR_HTT = {IDX_HTT, 2'b00};

    // Temperature control fields
    localparam int TSC_TEST_HI = 7;
    localparam int TSC_TEST_LO = 6;
    localparam int TSC_SRC_SEL  = 5;
    localparam int TSC_ROUTE_EN = 4;
    localparam int TSC_SENSE_EN = 3;
    localparam int TSC_HT_IE    = 1;
    localparam int TSC_HT_FLAG  = 0;

    // Low-voltage control fields
    localparam int LVC_LV_IE   = 1;
    localparam int LVC_LV_FLAG = 0;

    // Periodic wake control fields
    localparam int PWC_CLK    = 7;
    localparam int PWC_EXTSEL = 4;
    localparam int PWC_EA     = 3;
    localparam int PWC_FE     = 2;
    localparam int PWC_IE     = 1;
    localparam int PWC_IF     = 0;

    // Trim fields
    localparam int PWT_TRIM_HI = 7;
    localparam int PWT_TRIM_LO = 2;
    localparam int HTT_OEN     = 7;
    localparam int HTT_TRIM_HI = 3;
    localparam int HTT_TRIM_LO = 0;

    // Reset values
    localparam logic       ROUTE_RST = 1'b1;
    localparam logic       BIT_RST   = 1'b0;
    localparam logic [7:0] BYTE_RST  = 8'h00;
    localparam logic [7:0] RSVD_READ = 8'h00;

    // Regulator operating modes
    typedef enum logic [1:0] {
        MODE_SHUTDOWN,
        MODE_FULL,
        MODE_REDUCED
    } rtsr_mode_e;

endpackage

/* File: src/rtsr_regs.sv */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module rtsr_regs (
    input  wire logic                   pclk,               // Bus clock
    input  wire logic                   presetn,            // Reset, low
    input  wire logic                   psel,               // APB select
    input  wire logic                   penable,            // APB enable
    input  wire logic                   pwrite,             // APB write
    input  wire logic [rtsr_pkg::ADDR_W-1:0] paddr,         // Byte address
    input  wire logic [rtsr_pkg::DATA_W-1:0] pwdata,        // Write data
    input  wire logic [3:0]             pstrb,              // Byte strobes
    output logic [rtsr_pkg::DATA_W-1:0] prdata,             // Read data
    output logic                        pready,             // Always ready
    output logic                        pslverr,            // Error answer
    input  wire logic                   regulator_enable_pin, // Enable pin
    input  wire logic                   stop_mode_req,      // MCU in stop
    input  wire logic                   special_mode,       // Test access
    input  wire logic                   rsvd_abort_en,      // Abort option
    input  wire logic                   temp_above_assert,  // Comparator
    input  wire logic                   temp_below_release, // Comparator
    input  wire logic                   volt_below_assert,  // Comparator
    input  wire logic                   volt_above_release, // Comparator
    input  wire logic                   wake_timeout,       // Timer pulse
    input  wire logic                   wake_period_wave,   // Clock wave
    input  wire logic                   wake_pulse_wave,    // Pulse wave
    input  wire logic                   wake_route_en,      // Pin routed
    output logic                        full_performance_mode, // Mode
    output logic                        reduced_power_mode, // Mode
    output logic                        shutdown_mode,      // Mode
    output logic                        temp_sense_enable,  // Sensor on
    output logic                        vsrc_internal,      // Channel inner
    output logic                        vsrc_bandgap,       // Bandgap picked
    output logic                        high_temp_irq,      // Interrupt
    output logic                        low_voltage_irq,    // Interrupt
    output logic                        periodic_wake_irq,  // Interrupt
    output logic                        periodic_wake_output_pin, // Wave
    output logic                        wake_clk_sel,       // Timer clock
    output logic                        wake_enable,        // Timer run
    output logic [5:0]                  wake_trim,          // Timer trim
    output logic [15:0]                 wake_rate,          // Timer period
    output logic [3:0]                  temp_trim,          // Sensor trim
    output logic                        temp_trim_oen       // Trim enable
);
    import rtsr_pkg::*;

    logic             regen_s;
    logic             tabove_s;
    logic             tbelow_s;
    logic             vbelow_s;
    logic             vabove_s;
    rtsr_mode_e       mode_ff;
    rtsr_mode_e       nxt_mode;
    logic [1:0]       tsc_test_ff;
    logic             src_sel_ff;
    logic             route_en_ff;
    logic             sense_en_ff;
    logic             ht_status_ff;
    logic             nxt_ht_status;
    logic             ht_ie_ff;
    logic             ht_flag_ff;
    logic             lv_status_ff;
    logic             nxt_lv_status;
    logic             lv_ie_ff;
    logic             lv_flag_ff;
    logic             pw_clk_ff;
    logic             pw_extsel_ff;
    logic             pw_ea_ff;
    logic             pw_fe_ff;
    logic             pw_ie_ff;
    logic             pw_flag_ff;
    logic [5:0]       wake_trim_ff;
    logic [7:0]       rate_hi_ff;
    logic [7:0]       rate_lo_ff;
    logic             temp_oen_ff;
    logic [3:0]       temp_trim_ff;
    logic             wake_pin_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic [REG_W-1:0] rd_val;
    logic             addr_hit;
    logic             ht_change;
    logic             lv_change;
    logic             access;
    logic             wr_en;
    logic             wr_tsc;
    logic             wr_lvc;
    logic             wr_pwc;
    logic             wr_pwt;
    logic             wr_pwh;
    logic             wr_pwl;
    logic             wr_htt;

    ////////////////////////////////////////////////////////////////////////
    // Pin and comparator synchronisers
    rtsr_sync3 u_sync_regen (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (regulator_enable_pin),
        .sync_out (regen_s)
    );
    rtsr_sync3 u_sync_tabove (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (temp_above_assert),
        .sync_out (tabove_s)
    );
    rtsr_sync3 u_sync_tbelow (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (temp_below_release),
        .sync_out (tbelow_s)
    );
    rtsr_sync3 u_sync_vbelow (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (volt_below_assert),
        .sync_out (vbelow_s)
    );
    rtsr_sync3 u_sync_vabove (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (volt_above_release),
        .sync_out (vabove_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Operating mode
    // Enable pin and stop request pick mode
    always_comb begin
        if (!regen_s) begin
            nxt_mode = MODE_SHUTDOWN;
        end else if (stop_mode_req) begin
            nxt_mode = MODE_REDUCED;
        end else begin
            nxt_mode = MODE_FULL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= MODE_SHUTDOWN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign full_performance_mode = (mode_ff == MODE_FULL);
    assign reduced_power_mode    = (mode_ff == MODE_REDUCED);
    assign shutdown_mode         = (mode_ff == MODE_SHUTDOWN);

    ////////////////////////////////////////////////////////////////////////
    // APB decode: zero wait states, read data captured in setup
    assign access  = psel & penable;
    assign pready  = 1'b1;
    assign pslverr = access & (!addr_hit | (rsvd_abort_en &
                     (paddr == ADR_RSV)));
    assign wr_en   = access & pwrite & pstrb[0] & !pslverr;
    assign wr_tsc  = wr_en & (paddr == ADR_TSC);
    assign wr_lvc  = wr_en & (paddr == ADR_LVC);
    assign wr_pwc  = wr_en & (paddr == ADR_PWC);
    assign wr_pwt  = wr_en & (paddr == ADR_PWT);
    assign wr_pwh  = wr_en & (paddr == ADR_PWH);
    assign wr_pwl  = wr_en & (paddr == ADR_PWL);
    assign wr_htt  = wr_en & (paddr == ADR_HTT);

    // Read mux
    // Unused bits read zero
    always_comb begin
        addr_hit = 1'b1;
        rd_val   = BYTE_RST;
        unique case (paddr)
            ADR_TSC: rd_val = {tsc_test_ff, src_sel_ff, route_en_ff,
                               sense_en_ff, ht_status_ff, ht_ie_ff,
                               ht_flag_ff};
            ADR_LVC: rd_val = {5'h00, lv_status_ff, lv_ie_ff, lv_flag_ff};
            ADR_PWC: rd_val = {pw_clk_ff, 2'h0, pw_extsel_ff, pw_ea_ff,
                               pw_fe_ff, pw_ie_ff, pw_flag_ff};
            ADR_PWT: rd_val = {wake_trim_ff, 2'h0};
            ADR_PWH: rd_val = rate_hi_ff;
            ADR_PWL: rd_val = rate_lo_ff;
            ADR_RSV: rd_val = RSVD_READ;
            ADR_HTT: rd_val = {temp_oen_ff, 3'h0, temp_trim_ff};
            default: addr_hit = 1'b0;
        endcase
    end

    // Read data register, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (psel && !penable) begin
            prdata_ff <= {{(DATA_W-REG_W){1'b0}}, rd_val};
        end
    end

    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Temperature control settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsc_test_ff <= 2'h0;
            src_sel_ff  <= BIT_RST;
            route_en_ff <= ROUTE_RST;
            sense_en_ff <= BIT_RST;
            ht_ie_ff    <= BIT_RST;
        end else if (wr_tsc) begin
            if (special_mode) begin
                tsc_test_ff <= pwdata[TSC_TEST_HI:TSC_TEST_LO];
            end
            src_sel_ff  <= pwdata[TSC_SRC_SEL];
            route_en_ff <= pwdata[TSC_ROUTE_EN];
            sense_en_ff <= pwdata[TSC_SENSE_EN];
            ht_ie_ff    <= pwdata[TSC_HT_IE];
        end
    end

    assign vsrc_bandgap      = route_en_ff & src_sel_ff;
    assign vsrc_internal     = route_en_ff;
    assign temp_sense_enable = sense_en_ff;

    ////////////////////////////////////////////////////////////////////////
    // High-temperature status with hysteresis
    // Status only in full mode
    always_comb begin
        if (mode_ff != MODE_FULL || !sense_en_ff) begin
            nxt_ht_status = 1'b0;
        end else if (tabove_s) begin
            nxt_ht_status = 1'b1;
        end else if (tbelow_s) begin
            nxt_ht_status = 1'b0;
        end else begin
            nxt_ht_status = ht_status_ff;
        end
    end

    assign ht_change = (nxt_ht_status != ht_status_ff);

    // High-temperature status and flag; a set beats a clear
    // Leaving full mode clears status, which sets flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ht_status_ff <= BIT_RST;
            ht_flag_ff   <= BIT_RST;
        end else begin
            ht_status_ff <= nxt_ht_status;
            if (ht_change) begin
                ht_flag_ff <= 1'b1;
            end else if (wr_tsc && pwdata[TSC_HT_FLAG]) begin
                ht_flag_ff <= 1'b0;
            end
        end
    end

    assign high_temp_irq = ht_flag_ff & ht_ie_ff;

    ////////////////////////////////////////////////////////////////////////
    // Low-voltage status, flag and enable
    always_comb begin
        if (mode_ff != MODE_FULL) begin
            nxt_lv_status = 1'b0;
        end else if (vbelow_s) begin
            nxt_lv_status = 1'b1;
        end else if (vabove_s) begin
            nxt_lv_status = 1'b0;
        end else begin
            nxt_lv_status = lv_status_ff;
        end
    end

    assign lv_change = (nxt_lv_status != lv_status_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_status_ff <= BIT_RST;
            lv_flag_ff   <= BIT_RST;
            lv_ie_ff     <= BIT_RST;
        end else begin
            lv_status_ff <= nxt_lv_status;
            if (wr_lvc) begin
                lv_ie_ff <= pwdata[LVC_LV_IE];
            end
            if (lv_change) begin
                lv_flag_ff <= 1'b1;
            end else if (wr_lvc && pwdata[LVC_LV_FLAG]) begin
                lv_flag_ff <= 1'b0;
            end
        end
    end

    assign low_voltage_irq = lv_flag_ff & lv_ie_ff;

    ////////////////////////////////////////////////////////////////////////
    // Periodic wake control; clock select frozen while the timer runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_clk_ff    <= BIT_RST;
            pw_extsel_ff <= BIT_RST;
            pw_ea_ff     <= BIT_RST;
            pw_fe_ff     <= BIT_RST;
            pw_ie_ff     <= BIT_RST;
        end else if (wr_pwc) begin
            if (!pw_fe_ff && !pwdata[PWC_FE]) begin
                pw_clk_ff <= pwdata[PWC_CLK];
            end
            pw_extsel_ff <= pwdata[PWC_EXTSEL];
            pw_ea_ff     <= pwdata[PWC_EA];
            pw_fe_ff     <= pwdata[PWC_FE];
            pw_ie_ff     <= pwdata[PWC_IE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_flag_ff <= BIT_RST;
        end else if (wr_pwc && pwdata[PWC_IF]) begin
            pw_flag_ff <= 1'b0;
        end else if (wake_timeout && pw_fe_ff) begin
            pw_flag_ff <= 1'b1;
        end
    end

    assign periodic_wake_irq = pw_flag_ff & pw_ie_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_pin_ff <= 1'b0;
        end else begin
            wake_pin_ff <= wake_route_en & pw_ea_ff & pw_fe_ff &
                           (pw_extsel_ff ? wake_period_wave
                                         : wake_pulse_wave);
        end
    end

    assign periodic_wake_output_pin = wake_pin_ff;

    ////////////////////////////////////////////////////////////////////////
    // Trim and rate registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_trim_ff <= 6'h00;
            rate_hi_ff   <= BYTE_RST;
            rate_lo_ff   <= BYTE_RST;
            temp_oen_ff  <= BIT_RST;
            temp_trim_ff <= 4'h0;
        end else begin
            if (wr_pwt) begin
                wake_trim_ff <= pwdata[PWT_TRIM_HI:PWT_TRIM_LO];
            end
            if (wr_pwh) begin
                rate_hi_ff <= pwdata[REG_W-1:0];
            end
            if (wr_pwl) begin
                rate_lo_ff <= pwdata[REG_W-1:0];
            end
            if (wr_htt) begin
                temp_oen_ff  <= pwdata[HTT_OEN];
                temp_trim_ff <= pwdata[HTT_TRIM_HI:HTT_TRIM_LO];
            end
        end
    end

    assign wake_clk_sel  = pw_clk_ff;
    assign wake_enable   = pw_fe_ff;
    assign wake_trim     = wake_trim_ff;
    assign wake_rate     = {rate_hi_ff, rate_lo_ff};
    assign temp_trim     = temp_trim_ff;
    assign temp_trim_oen = temp_oen_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mode_follows_pin: assert property (
        !regen_s |=> shutdown_mode && !full_performance_mode)
        else $error("enable pin low but not in shutdown");
    a_rsvd_abort: assert property (
        access && rsvd_abort_en && paddr == ADR_RSV |-> pslverr)
        else $error("reserved slot access not aborted");
    a_wake_pin_gate: assert property (
        !pw_ea_ff || !pw_fe_ff |=> !periodic_wake_output_pin)
        else $error("wake pin active while access disabled");
    a_test_bits_lock: assert property (
        !special_mode |=> $stable(tsc_test_ff))
        else $error("test bits changed outside special mode");
    a_bandgap_route: assert property (
        vsrc_bandgap |-> vsrc_internal && src_sel_ff)
        else $error("bandgap routed without access enable");
    a_status_mode: assert property (
        !full_performance_mode || !sense_en_ff |=> !ht_status_ff)
        else $error("high temp status set outside full mode");
    a_htflag_set: assert property (
        $changed(ht_status_ff) |-> ht_flag_ff)
        else $error("status change did not set flag");
    a_htflag_hold: assert property (
        ht_flag_ff && !(wr_tsc && pwdata[TSC_HT_FLAG]) |=> ht_flag_ff)
        else $error("high temp flag lost without clear");
    a_htflag_clear: assert property (
        wr_tsc && pwdata[TSC_HT_FLAG] && !ht_change |=> !ht_flag_ff)
        else $error("write one did not clear flag");
    a_ht_irq_cause: assert property (
        high_temp_irq |-> ht_flag_ff && ht_ie_ff)
        else $error("irq without flag and enable");
    a_lvflag_set: assert property (
        $changed(lv_status_ff) |-> lv_flag_ff)
        else $error("low-voltage change did not set flag");
    a_wake_clear_wins: assert property (
        wr_pwc && pwdata[PWC_IF] |=> !pw_flag_ff)
        else $error("wake flag clear lost to set");

    c_ht_flag_cycle: cover property (
        ht_flag_ff ##[1:20] !ht_flag_ff);
    c_rsvd_abort: cover property (access && pslverr && paddr == ADR_RSV);
    c_wake_race: cover property (
        wr_pwc && pwdata[PWC_IF] && wake_timeout && pw_fe_ff);

endmodule

`default_nettype wire

/* File: src/rtsr_sync3.sv */
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Three-stage synchroniser; the output follows once stages two and three
// agree, which filters a single metastable resolution.
module rtsr_sync3 (
    input  wire logic pclk,     // Bus clock
    input  wire logic presetn,  // Async reset, active low
    input  wire logic async_in, // Input from another domain
    output logic      sync_out  // Settled value
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic stable_ff;

    // Shift chain; only stage two reads stage one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Take a new value when the two late stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            stable_ff <= s3_ff;
        end
    end

    assign sync_out = stable_ff;

endmodule

`default_nettype wire

/* File: test/rtsr_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import rtsr_pkg::*;

    logic        pclk = 1'h0, presetn = 1'h0, pready, pslverr, er;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    // enable pin held high for the whole run
    logic        en_pin = 1'h1, stop = 1'h0, spec = 1'h0, abrt = 1'h0;
    logic        t_hi = 1'h0, t_lo = 1'h1, v_lo = 1'h0, v_hi = 1'h1;
    logic        w_to = 1'h0, w_pul = 1'h0, w_rt = 1'h0;
    logic        md_full, md_low, md_off, tse, vint, vbg, hti, lvi, pwi;
    logic        wpin, clk_sel, w_en, oen, w_per = 1'h0;
    logic [15:0] rate;
    logic [5:0]  wtrim;
    logic [3:0]  ttrim;
    int          err_total = 0, checks = 0;

    // Bus clock, 25 ns period
    always #12.5 pclk = ~pclk;

    rtsr_regs i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .regulator_enable_pin(en_pin), .stop_mode_req(stop),
        .special_mode(spec), .rsvd_abort_en(abrt),
        .temp_above_assert(t_hi), .temp_below_release(t_lo),
        .volt_below_assert(v_lo), .volt_above_release(v_hi),
        .wake_timeout(w_to), .wake_period_wave(w_per),
        .wake_pulse_wave(w_pul), .wake_route_en(w_rt),
        .full_performance_mode(md_full), .reduced_power_mode(md_low),
        .shutdown_mode(md_off), .temp_sense_enable(tse),
        .vsrc_internal(vint), .vsrc_bandgap(vbg), .high_temp_irq(hti),
        .low_voltage_irq(lvi), .periodic_wake_irq(pwi),
        .periodic_wake_output_pin(wpin), .wake_clk_sel(clk_sel),
        .wake_enable(w_en), .wake_trim(wtrim), .wake_rate(rate),
        .temp_trim(ttrim), .temp_trim_oen(oen)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One comparison, case equality so unknowns fail
    task automatic check(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Single-bit comparison
    task automatic chkb(input string nm, input logic got, exp);
        check(nm, {31'h0, got}, {31'h0, exp});
    endtask

    // APB transfer: setup, then access held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask

    // Read a register and compare its byte
    task automatic rchk(input logic [11:0] a, input logic [7:0] e,
                        input string nm);
        xfer(1'h0, a, 8'h00);
        check(nm, rd, {24'h000000, e});
    endtask

    // Write, then read back
    task automatic wrd(input logic [11:0] a, input logic [7:0] d, e,
                       input string nm);
        xfer(1'h1, a, d);
        rchk(a, e, nm);
    endtask

    // Give synchronisers and status registers time to follow
    task automatic settle();
        repeat (12) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        rchk(ADR_TSC, 8'h10, "tsc rst");
        rchk(ADR_LVC, 8'h00, "lvc rst");
        chkb("vint", vint, 1'h1);
        settle();
        chkb("mode full", md_full, 1'h1);
        chkb("mode off", md_off, 1'h0);
        $display("end of test reset");
        wrd(ADR_TSC, 8'hfa, 8'h3a, "tsc user");
        chkb("tse", tse, 1'h1);
        chkb("vbg", vbg, 1'h1);
        @(posedge pclk);
        spec <= 1'h1;
        wrd(ADR_TSC, 8'hca, 8'hca, "tsc spec");
        wrd(ADR_TSC, 8'h0a, 8'h0a, "tsc clr");
        chkb("vint", vint, 1'h0);
        $display("end of test control");
        @(posedge pclk);
        t_hi <= 1'h1;
        t_lo <= 1'h0;
        settle();
        rchk(ADR_TSC, 8'h0f, "tsc hot");
        chkb("hti", hti, 1'h1);
        wrd(ADR_TSC, 8'h0a, 8'h0f, "flag w0");
        wrd(ADR_TSC, 8'h09, 8'h0c, "flag w1");
        @(posedge pclk);
        stop <= 1'h1;
        settle();
        chkb("mode low", md_low, 1'h1);
        rchk(ADR_TSC, 8'h09, "tsc low power");
        chkb("hti", hti, 1'h0);
        @(posedge pclk);
        stop <= 1'h0;
        settle();
        $display("end of test temperature");
        xfer(1'h1, ADR_LVC, 8'h02);
        @(posedge pclk);
        v_lo <= 1'h1;
        v_hi <= 1'h0;
        settle();
        rchk(ADR_LVC, 8'h07, "lvc low");
        chkb("lvi", lvi, 1'h1);
        wrd(ADR_LVC, 8'h03, 8'h06, "lvc clr");
        $display("end of test voltage");
        rchk(ADR_RSV, 8'h00, "rsv");
        chkb("rsv err", er, 1'h0);
        @(posedge pclk);
        abrt <= 1'h1;
        xfer(1'h0, ADR_RSV, 8'h00);
        chkb("rsv abort", er, 1'h1);
        wrd(ADR_PWT, 8'hff, 8'hfc, "pwt");
        wrd(ADR_HTT, 8'hff, 8'h8f, "htt");
        check("wake trim", {26'h0, wtrim}, 32'h3f);
        check("temp trim", {28'h0, ttrim}, 32'hf);
        chkb("trim oen", oen, 1'h1);
        wrd(ADR_PWH, 8'ha5, 8'ha5, "pwh");
        wrd(ADR_PWL, 8'h3c, 8'h3c, "pwl");
        check("rate", {16'h0, rate}, 32'ha53c);
        $display("end of test map");
        @(posedge pclk);
        w_rt <= 1'h1;
        w_pul <= 1'h1;
        wrd(ADR_PWC, 8'h80, 8'h80, "pwc clk");
        wrd(ADR_PWC, 8'h0e, 8'h8e, "pwc");
        chkb("clk sel", clk_sel, 1'h1);
        chkb("wake en", w_en, 1'h1);
        chkb("wpin", wpin, 1'h1);
        @(posedge pclk);
        w_to <= 1'h1;
        @(posedge pclk);
        w_to <= 1'h0;
        rchk(ADR_PWC, 8'h8f, "pwc flag");
        chkb("pwi", pwi, 1'h1);
        @(posedge pclk);
        w_pul <= 1'h0;
        w_per <= 1'h1;
        wrd(ADR_PWC, 8'h1e, 8'h9f, "pwc ext");
        chkb("wpin ext", wpin, 1'h1);
        $display("end of test wake");
        summarize();
    end
endmodule

`default_nettype wire
